// >>> scan_list_pkg.sv
// shared constants, field layout and types of the channel scan list
package scan_list_pkg;

    // geometry
    localparam int ENTRY_DEPTH = 512;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 5;
    localparam int RESULT_W = 16;

    // register offsets from the board base
    localparam logic [ADDR_W-1:0] ENTRY_OFFSET = 5'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 5'h0A;
    localparam logic [ADDR_W-1:0] READ_PTR_OFFSET = 5'h0C;

    // entry field positions
    localparam int SE_BIT = 15;
    localparam int SENSE_BIT = 14;
    localparam int CAL_BIT = 13;
    localparam int BIP_BIT = 12;
    localparam int CHAN_LSB = 6;
    localparam int CHAN_W = 4;
    localparam int GAIN_LSB = 3;
    localparam int GAIN_W = 3;
    localparam int END_BIT = 2;
    localparam int GHOST_BIT = 1;
    localparam int DSP_BIT = 0;

    // status register fields
    localparam int STAT_FULL_BIT = 10;
    localparam int STAT_END_BIT = 11;

    // reset values
    localparam logic [WORD_W-1:0] ENTRY_RESET = 16'h0000;
    localparam logic [GAIN_W-1:0] GAIN_INVALID = 3'h0;

    typedef enum logic [2:0] {
        MODE_DIFFERENTIAL_INPUT_MODE = 3'b000,
        MODE_RSE = 3'b001,
        MODE_NON_REFERENCED_SINGLE_ENDED = 3'b010,
        MODE_OFFSET_CAL = 3'b011,
        MODE_GAIN_CAL = 3'b100
    } input_mode_type;

    typedef logic [6:0] gain_factor_type;

    // amplifier gain for each gain code, zero for the invalid code
    localparam gain_factor_type GAIN_TABLE [8] = '{
        7'h00, 7'h01, 7'h02, 7'h05, 7'h0A, 7'h14, 7'h32, 7'h64
    };

    function automatic input_mode_type decode_mode(input logic [WORD_W-1:0] e);
        if (e[CAL_BIT]) begin
            return e[SENSE_BIT] ? MODE_GAIN_CAL : MODE_OFFSET_CAL;
        end
        if (!e[SE_BIT]) begin
            return MODE_DIFFERENTIAL_INPUT_MODE;
        end
        return e[SENSE_BIT] ? MODE_NON_REFERENCED_SINGLE_ENDED : MODE_RSE;
    endfunction

endpackage

// >>> scan_mem_if.sv
// port bundle between the scan list control and its entry store
`timescale 1ns/1ps
`default_nettype none
interface scan_mem_if
    import scan_list_pkg::*;
#(
    parameter int PTR_W = 9
) ();
    logic wr_en;
    logic [PTR_W-1:0] wr_addr;
    logic [WORD_W-1:0] wr_data;
    logic [PTR_W-1:0] rd_addr;
    logic [WORD_W-1:0] rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
        input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
        output rd_data);
endinterface
`default_nettype wire

// >>> scan_entry_store.sv
// entry memory of the scan list, write port plus combinational read port
`timescale 1ns/1ps
`default_nettype none
module scan_entry_store
    import scan_list_pkg::*;
#(
    parameter int DEPTH = ENTRY_DEPTH
) (
    // clock
    input wire logic mclk,
    // memory ports
    scan_mem_if.store mem
);
    logic [WORD_W-1:0] cells [DEPTH];

    always_ff @(posedge mclk) begin
        if (mem.wr_en) begin
            cells[mem.wr_addr] <= mem.wr_data;
        end
    end

    // combinational read so back-to-back steps see the new slot at once
    assign mem.rd_data = cells[mem.rd_addr];
endmodule
`default_nettype wire

// >>> adc_channel_scan_list.sv
// channel scan list: entry loading, list sequencing and per-conversion decode
//
// Overview of operation
// - list memory holds up to 512 entries, one per conversion of a scan
// - entries are written at offset 08; reading there returns zero
// - channel field picks input N, or pair N mod 8 and N mod 8 plus 8
// - gain field codes 1 to 7 give gains 1,2,5,10,20,50,100; 0 invalid
// - mode from single-ended, sense and calibration bits, including cal routes
// - calibration bit detaches input multiplexers, routes internal references
// - bipolar bit gives sign-extended two's complement, else straight binary
// - several end markers may sit in one list for interval scanning
// - ghost entries convert but their result is not pushed to the FIFO
// - ghost conversions give no sample count pulse when counting source 4
// - dsp bit forwards the result to the DSP, independent of storing
// - clear strobe restarts writing at the first location, then writes advance
// - load strobe makes the first entry active; list stays primed
// - every conversion trigger advances the active entry to the next one
// - at the end of the written list the pointer wraps to the first
// - acquisition clear rewinds the pointer, keeps entries, load still needed
// - repeated loads reload a single entry, else step through the list
// - each finished non-ghost conversion pushes one result into the FIFO
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_scan_list
    import scan_list_pkg::*;
#(
    parameter int DEPTH = ENTRY_DEPTH,
    parameter int RAW_W = RESULT_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [WORD_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [WORD_W-1:0] reg_rdata_q,
    // event strobes from the strobe decode
    input wire logic scan_list_clear_strobe,
    input wire logic scan_list_load_strobe,
    input wire logic acq_clear_strobe,
    // conversion triggers
    input wire logic external_convert_input,
    input wire logic scan_counter_pulse,
    // converter result
    input wire logic adc_done,
    input wire logic [RAW_W-1:0] adc_result,
    input wire logic sample_src4_select,
    // active entry decode
    output input_mode_type mode_q,
    output logic [CHAN_W-1:0] pos_mux_q,
    output logic [CHAN_W-1:0] neg_mux_q,
    output logic mux_detach_q,
    output logic [GAIN_W-1:0] gain_code_q,
    output gain_factor_type gain_factor_q,
    output logic gain_valid_q,
    output logic bipolar_q,
    output logic sequence_end_q,
    // result routing
    output logic fifo_push_q,
    output logic [WORD_W-1:0] fifo_data_q,
    output logic sample_count_pulse_q,
    output logic dsp_send_q,
    output logic [WORD_W-1:0] dsp_data_q
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_ZERO = '0;

    logic [CNT_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [WORD_W-1:0] active_q;
    logic [WORD_W-1:0] active_d;
    logic [WORD_W-1:0] conv_entry_q;
    logic [WORD_W-1:0] fifo_data_d;
    logic [RAW_W-1:0] bip_raw;
    logic full;
    logic entry_wr;
    logic trig;
    logic step;
    logic rd_last;

    scan_mem_if #(.PTR_W(PTR_W)) mem ();

    scan_entry_store #(.DEPTH(DEPTH)) store (
        .mclk(mclk),
        .mem(mem.store)
    );

    // write side
    assign full = (wr_ptr_q == CNT_FULL);
    assign entry_wr = reg_wr && (reg_addr == ENTRY_OFFSET) && !full
        && !scan_list_clear_strobe;
    assign mem.wr_en = entry_wr;
    assign mem.wr_addr = wr_ptr_q[PTR_W-1:0];
    assign mem.wr_data = reg_wdata;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ptr_q <= CNT_ZERO;
        end else if (scan_list_clear_strobe) begin
            wr_ptr_q <= CNT_ZERO;
        end else if (entry_wr) begin
            wr_ptr_q <= CNT_W'(wr_ptr_q + CNT_ONE);
        end
    end

    // read side: load strobes and conversion triggers share one step
    assign trig = external_convert_input || scan_counter_pulse;
    assign step = (scan_list_load_strobe || trig) && !scan_list_clear_strobe
        && !acq_clear_strobe && (wr_ptr_q != CNT_ZERO);
    assign rd_last = ({1'b0, rd_ptr_q} == CNT_W'(wr_ptr_q - CNT_ONE));
    assign mem.rd_addr = rd_ptr_q;
    assign active_d = step ? mem.rd_data : active_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_ptr_q <= PTR_ZERO;
        end else if (scan_list_clear_strobe || acq_clear_strobe) begin
            rd_ptr_q <= PTR_ZERO;
        end else if (step) begin
            // end markers do not wrap; only the written length does
            rd_ptr_q <= rd_last ? PTR_ZERO : PTR_W'(rd_ptr_q + 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            active_q <= ENTRY_RESET;
        end else begin
            active_q <= active_d;
        end
    end

    // entry in force while a conversion runs
    always_ff @(posedge mclk) begin
        if (rst) begin
            conv_entry_q <= ENTRY_RESET;
        end else if (trig) begin
            conv_entry_q <= active_q;
        end
    end

    // decode of the entry that becomes active
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q <= MODE_DIFFERENTIAL_INPUT_MODE;
            pos_mux_q <= '0;
            // reset entry decodes as differential pair 0 and 8
            neg_mux_q <= {1'b1, {(CHAN_W-1){1'b0}}};
            mux_detach_q <= 1'b0;
            gain_code_q <= GAIN_INVALID;
            gain_factor_q <= GAIN_TABLE[GAIN_INVALID];
            gain_valid_q <= 1'b0;
            bipolar_q <= 1'b0;
            sequence_end_q <= 1'b0;
        end else begin
            mode_q <= decode_mode(active_d);
            mux_detach_q <= active_d[CAL_BIT];
            if (decode_mode(active_d) == MODE_DIFFERENTIAL_INPUT_MODE) begin
                pos_mux_q <= {1'b0, active_d[CHAN_LSB +: CHAN_W-1]};
                neg_mux_q <= {1'b1, active_d[CHAN_LSB +: CHAN_W-1]};
            end else begin
                pos_mux_q <= active_d[CHAN_LSB +: CHAN_W];
                neg_mux_q <= '0;
            end
            gain_code_q <= active_d[GAIN_LSB +: GAIN_W];
            gain_factor_q <= GAIN_TABLE[active_d[GAIN_LSB +: GAIN_W]];
            gain_valid_q <= active_d[GAIN_LSB +: GAIN_W] != GAIN_INVALID;
            bipolar_q <= active_d[BIP_BIT];
            sequence_end_q <= active_d[END_BIT];
        end
    end

    // result formatting: raw offset binary, msb flipped for two's complement
    assign bip_raw = {~adc_result[RAW_W-1], adc_result[RAW_W-2:0]};
    assign fifo_data_d = conv_entry_q[BIP_BIT]
        ? WORD_W'(signed'(bip_raw)) : WORD_W'(adc_result);

    always_ff @(posedge mclk) begin
        if (rst) begin
            fifo_push_q <= 1'b0;
            fifo_data_q <= '0;
            sample_count_pulse_q <= 1'b0;
        end else begin
            fifo_push_q <= adc_done && !conv_entry_q[GHOST_BIT];
            sample_count_pulse_q <= adc_done && sample_src4_select
                && !conv_entry_q[GHOST_BIT];
            if (adc_done) begin
                fifo_data_q <= fifo_data_d;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dsp_send_q <= 1'b0;
            dsp_data_q <= '0;
        end else begin
            dsp_send_q <= adc_done && conv_entry_q[DSP_BIT];
            if (adc_done && conv_entry_q[DSP_BIT]) begin
                dsp_data_q <= fifo_data_d;
            end
        end
    end

    // register reads; the entry port is write-only
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    STATUS_OFFSET: begin
                        reg_rdata_q <= WORD_W'(wr_ptr_q);
                        reg_rdata_q[STAT_FULL_BIT] <= full;
                        reg_rdata_q[STAT_END_BIT] <= active_q[END_BIT];
                    end
                    READ_PTR_OFFSET: begin
                        reg_rdata_q <= WORD_W'(rd_ptr_q);
                    end
                    default: begin
                        reg_rdata_q <= '0;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence list_step_s;
        step && !rd_last;
    endsequence

    sequence list_wrap_s;
        step && rd_last;
    endsequence

    sequence done_s;
        adc_done;
    endsequence

    sequence conv_s;
        trig;
    endsequence

    full_ignore_a: assert property (
        (reg_wr && reg_addr == ENTRY_OFFSET && full && !scan_list_clear_strobe)
        |=> wr_ptr_q == CNT_FULL && !$past(mem.wr_en))
        else $error("write to full list changed the write pointer");

    write_advance_a: assert property (
        (reg_wr && reg_addr == ENTRY_OFFSET && !full && !scan_list_clear_strobe)
        |=> wr_ptr_q == CNT_W'($past(wr_ptr_q) + CNT_ONE))
        else $error("entry write did not advance the write pointer");

    clear_restart_a: assert property (
        scan_list_clear_strobe |=> wr_ptr_q == CNT_ZERO && rd_ptr_q == PTR_ZERO)
        else $error("clear strobe did not restart the list");

    acq_rewind_a: assert property (
        (acq_clear_strobe && !scan_list_clear_strobe)
        |=> rd_ptr_q == PTR_ZERO && $stable(wr_ptr_q) && $stable(active_q))
        else $error("acquisition clear lost entries or did not rewind");

    list_wrap_a: assert property (
        list_wrap_s |=> rd_ptr_q == PTR_ZERO)
        else $error("list did not wrap after its last entry");

    list_step_a: assert property (
        list_step_s |=> rd_ptr_q == PTR_W'($past(rd_ptr_q) + 1'b1))
        else $error("trigger or load did not step the list");

    load_active_a: assert property (
        step |=> active_q == $past(mem.rd_data) && mode_q == decode_mode(active_q))
        else $error("stepped entry did not become active");

    single_reload_a: assert property (
        (step && wr_ptr_q == CNT_ONE) |=> rd_ptr_q == PTR_ZERO)
        else $error("one-entry list moved off its entry");

    ghost_store_a: assert property (
        (done_s and conv_entry_q[GHOST_BIT]) |=> !fifo_push_q && !sample_count_pulse_q)
        else $error("ghost conversion reached the FIFO or counter");

    normal_store_a: assert property (
        (done_s and !conv_entry_q[GHOST_BIT]) |=> fifo_push_q ##1 !fifo_push_q || $past(adc_done))
        else $error("normal conversion was not pushed exactly once");

    count_src4_a: assert property (
        sample_count_pulse_q |-> $past(adc_done && sample_src4_select && !conv_entry_q[GHOST_BIT]))
        else $error("sample count pulse without a counted conversion");

    dsp_forward_a: assert property (
        done_s |=> dsp_send_q == $past(conv_entry_q[DSP_BIT]))
        else $error("dsp forwarding does not follow the entry flag");

    bipolar_format_a: assert property (
        (done_s and conv_entry_q[BIP_BIT])
        |=> fifo_data_q[WORD_W-1] == !$past(adc_result[RAW_W-1]))
        else $error("bipolar result sign wrong");

    differential_input_mode_pair_a: assert property (
        mode_q == MODE_DIFFERENTIAL_INPUT_MODE |-> neg_mux_q == (pos_mux_q | 4'h8) && !pos_mux_q[CHAN_W-1])
        else $error("differential pair mapping wrong");

    cal_detach_a: assert property (
        mux_detach_q == (mode_q == MODE_OFFSET_CAL || mode_q == MODE_GAIN_CAL))
        else $error("calibration routing disagrees with mode");

    gain_valid_a: assert property (
        gain_valid_q == (gain_factor_q != 7'h00))
        else $error("gain validity disagrees with gain factor");

    entry_read_a: assert property (
        (reg_rd && reg_addr == ENTRY_OFFSET) |=> reg_rdata_q == 16'h0000)
        else $error("entry location returned data on read");

    conv_latch_a: assert property (
        conv_s |=> conv_entry_q == $past(active_q))
        else $error("conversion did not take the active entry");

    unipolar_format_a: assert property (
        (done_s and !conv_entry_q[BIP_BIT])
        |=> fifo_data_q == WORD_W'($past(adc_result)))
        else $error("unipolar result not straight binary");

    status_fill_a: assert property (
        (reg_rd && reg_addr == STATUS_OFFSET) |=> reg_rdata_q[CNT_W-1:0] == $past(wr_ptr_q)
        && reg_rdata_q[STAT_FULL_BIT] == ($past(wr_ptr_q) == CNT_FULL))
        else $error("status fill count or full flag wrong");
endmodule
`default_nettype wire

// >>> adc_converter_model.sv
// converter model: answers each conversion trigger with a done pulse and a result
`timescale 1ns/1ps
`default_nettype none
module adc_converter_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // trigger side
    input wire logic trigger,
    input wire logic [3:0] latency,
    input wire logic [15:0] next_value,
    // result side
    output logic adc_done,
    output logic [15:0] adc_result
);
    logic [3:0] wait_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wait_q <= 4'h0;
            adc_done <= 1'b0;
            adc_result <= 16'hFFFF;
        end else begin
            // done only after the trigger edge of its own conversion
            adc_done <= (wait_q == 4'h1);
            // result valid only with done, otherwise a toggling pattern
            adc_result <= (wait_q == 4'h1) ? next_value : ~adc_result;
            if (trigger) begin
                wait_q <= latency;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> adc_channel_scan_list_bench.sv
// self-checking bench of the channel scan list with a converter model
`timescale 1ns/1ps
`default_nettype none
module adc_channel_scan_list_bench
    import scan_list_pkg::*;
;
    localparam int DEPTH_T = 8;
    localparam logic [6:0] GAINS [8] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h0A, 7'h14, 7'h32, 7'h64};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 5'h00;
    logic [WORD_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [4:0] pulses = 5'h00;
    logic src4 = 1'b1;
    logic [3:0] latency = 4'h1;
    logic [15:0] next_value = 16'h0000;
    wire logic adc_done;
    wire logic [15:0] adc_result;
    wire logic conv_trig;
    logic [WORD_W-1:0] reg_rdata_q, fifo_data_q, dsp_data_q, last_fifo, last_dsp;
    input_mode_type mode_q;
    logic [CHAN_W-1:0] pos_mux_q, neg_mux_q;
    logic [GAIN_W-1:0] gain_code_q;
    gain_factor_type gain_factor_q;
    logic mux_detach_q, gain_valid_q, bipolar_q, sequence_end_q;
    logic fifo_push_q, sample_count_pulse_q, dsp_send_q;
    int mismatches = 0;
    int comparisons = 0;
    int pushes = 0;
    int counts = 0;
    int sends = 0;

    always #5 mclk = ~mclk;
    assign conv_trig = pulses[3] | pulses[4];

    adc_channel_scan_list #(.DEPTH(DEPTH_T), .RAW_W(16)) i_adc_channel_scan_list (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .scan_list_clear_strobe(pulses[0]), .scan_list_load_strobe(pulses[1]),
        .acq_clear_strobe(pulses[2]), .external_convert_input(pulses[3]),
        .scan_counter_pulse(pulses[4]), .adc_done(adc_done), .adc_result(adc_result),
        .sample_src4_select(src4), .mode_q(mode_q), .pos_mux_q(pos_mux_q),
        .neg_mux_q(neg_mux_q), .mux_detach_q(mux_detach_q), .gain_code_q(gain_code_q),
        .gain_factor_q(gain_factor_q), .gain_valid_q(gain_valid_q), .bipolar_q(bipolar_q),
        .sequence_end_q(sequence_end_q), .fifo_push_q(fifo_push_q),
        .fifo_data_q(fifo_data_q), .sample_count_pulse_q(sample_count_pulse_q),
        .dsp_send_q(dsp_send_q), .dsp_data_q(dsp_data_q)
    );

    adc_converter_model i_adc_converter_model (
        .mclk(mclk), .rst(rst), .trigger(conv_trig), .latency(latency),
        .next_value(next_value), .adc_done(adc_done), .adc_result(adc_result)
    );

    // result pulses are one cycle wide, so sample them mid-cycle
    always @(negedge mclk) begin
        if (fifo_push_q === 1'b1) begin
            pushes++;
            last_fifo = fifo_data_q;
        end
        if (sample_count_pulse_q === 1'b1) begin
            counts++;
        end
        if (dsp_send_q === 1'b1) begin
            sends++;
            last_dsp = dsp_data_q;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_check(input logic [4:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata_q, exp);
    endtask

    // index: 0 clear, 1 load, 2 acquisition clear, 3 convert input, 4 scan counter
    task automatic strobe(input int k);
        @(posedge mclk);
        pulses[k] <= 1'b1;
        @(posedge mclk);
        pulses[k] <= 1'b0;
        #1;
    endtask

    task automatic conv(input int k, input logic [15:0] raw, input logic [3:0] lat);
        next_value <= raw;
        latency <= lat;
        strobe(k);
        repeat (int'(lat) + 4) @(posedge mclk);
        #1;
    endtask

    // top nibble: single-ended, sense, calibration, bipolar; low: end, ghost, dsp
    function automatic logic [15:0] ent(input logic [3:0] top, input logic [3:0] chan,
        input logic [2:0] gain, input logic [2:0] low);
        return {top, 2'b00, chan, gain, low};
    endfunction

    function automatic logic [15:0] mode_entry(input int i);
        return ent({i[0], i[1], i[2], i[0]}, 4'(i * 3 + 9), 3'(i), 3'b000);
    endfunction

    function automatic logic [2:0] exp_mode(input logic [15:0] e);
        return e[CAL_BIT] ? (e[SENSE_BIT] ? MODE_GAIN_CAL : MODE_OFFSET_CAL) :
            (!e[SE_BIT] ? MODE_DIFFERENTIAL_INPUT_MODE : (e[SENSE_BIT] ? MODE_NON_REFERENCED_SINGLE_ENDED : MODE_RSE));
    endfunction

    task automatic check_active(input logic [15:0] e);
        logic differential_input_mode;
        differential_input_mode = !e[CAL_BIT] && !e[SE_BIT];
        check(16'(mode_q), 16'(exp_mode(e)));
        check(16'(mux_detach_q), 16'(e[CAL_BIT]));
        if (!e[CAL_BIT]) begin
            check(16'(pos_mux_q), differential_input_mode ? 16'(e[8:6]) : 16'(e[9:6]));
            check(16'(neg_mux_q), differential_input_mode ? 16'({1'b1, e[8:6]}) : 16'h0000);
        end
        check(16'({gain_factor_q, gain_valid_q}), 16'({GAINS[e[5:3]], e[5:3] != 3'h0}));
        check(16'({gain_code_q, bipolar_q, sequence_end_q}), 16'({e[5:3], e[12], e[2]}));
    endtask

    initial begin
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
        a = ent(4'b0001, 4'h3, 3'h1, 3'b101);
        b = ent(4'b1000, 4'hA, 3'h2, 3'b011);
        c = ent(4'b1100, 4'hF, 3'h7, 3'b100);
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rd_check(STATUS_OFFSET, 16'h0000);
        rd_check(ENTRY_OFFSET, 16'h0000);
        rd_check(5'h1E, 16'h0000);
        // three entries, two end markers, results through every path
        strobe(0);
        wr(ENTRY_OFFSET, a);
        wr(ENTRY_OFFSET, b);
        wr(ENTRY_OFFSET, c);
        rd_check(STATUS_OFFSET, 16'h0003);
        strobe(1);
        check_active(a);
        conv(3, 16'h8001, 4'h1);
        check(16'(pushes * 256 + counts * 16 + sends), 16'h0111);
        check(last_fifo, 16'h0001);
        check(last_dsp, 16'h0001);
        check_active(b);
        strobe(2);
        check_active(b);
        rd_check(READ_PTR_OFFSET, 16'h0000);
        strobe(1);
        check_active(a);
        rd_check(READ_PTR_OFFSET, 16'h0001);
        conv(4, 16'h7FFF, 4'h6);
        check(last_fifo, 16'hFFFF);
        check(last_dsp, 16'hFFFF);
        conv(3, 16'h5555, 4'h2);
        check(16'(pushes * 256 + counts * 16 + sends), 16'h0223);
        check(last_dsp, 16'h5555);
        src4 <= 1'b0;
        conv(4, 16'h1234, 4'h3);
        check(16'(pushes * 256 + counts * 16 + sends), 16'h0323);
        check(last_fifo, 16'h1234);
        check_active(a);
        rd_check(STATUS_OFFSET, 16'h0803);
        // every gain code and every input mode, stepped by loads
        strobe(0);
        for (int i = 0; i < 8; i++) begin
            wr(ENTRY_OFFSET, mode_entry(i));
        end
        for (int i = 0; i < 8; i++) begin
            strobe(1);
            check_active(mode_entry(i));
        end
        // single entry reloads
        strobe(0);
        wr(ENTRY_OFFSET, b);
        for (int i = 0; i < 3; i++) begin
            strobe(1);
            check_active(b);
        end
        rd_check(READ_PTR_OFFSET, 16'h0000);
        // one write beyond capacity is dropped
        strobe(0);
        for (int i = 0; i <= DEPTH_T; i++) begin
            wr(ENTRY_OFFSET, ent(4'b1000, 4'(i), 3'h1, 3'b000));
        end
        strobe(1);
        rd_check(STATUS_OFFSET, 16'h0400 | 16'(DEPTH_T));
        for (int i = 1; i <= DEPTH_T; i++) begin
            strobe(1);
            check(16'(pos_mux_q), 16'(i % DEPTH_T));
        end
        report_and_stop();
    end

    // watchdog well beyond the fewer than two hundred cycles the tests take
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
